// >>> system_clock_mode_control.sv
// System clock source selection, oscillator control and halt-mode sequencing
// Operation
// RULE1: Select field: 000 fast, 001-110 fast divided by 2..64, 111 slow.
// RULE2: Fast keep bit decides whether fast oscillator runs during halt.
// RULE3: Slow keep bit decides whether slow oscillator runs during halt. The code also keeps it on while the watchdog is enabled.
// RULE4: Read-only stable flag shows fast oscillator stability.
// RULE5: Enabling fast oscillator clears stable flag, sets it once stable.
// RULE6: Fast enable bit switches fast oscillator; resets to one. The code lets a cleared bit stop it only with select 111, outside halt.
// RULE7: Halt mode chosen only from the two keep bits.
// RULE8: Select 111 moves to slow clock once slow oscillator is stable.
// RULE9: Codes 000-110 return to fast division; software polls stable flag.
// RULE10: Halt with both keep bits zero sleeps; only watchdog runs.
// RULE11: Fast keep 0, slow keep 1: fast clock and program stop.
// RULE12: Both keep bits one: program stops, both clocks run.
// RULE13: Fast keep 1, slow keep 0: fast runs, slow stops. The code keeps slow oscillator and tick on while the watchdog is enabled.
// RULE14: While halted, memory, registers and port states are held.
// RULE15: Halt sets power-down flag and clears timeout flag.
// RULE16: Halt clears watchdog; it counts on only if enabled.
// RULE17: Fast clock from fast oscillator, slow clock from slow oscillator.
// RULE18: Clock source and ratio changes are glitch free.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module system_clock_mode_control
  import clk_mode_pkg::*;
#(
  parameter int unsigned FAST_STAB = FAST_STAB_CYC,
  parameter int unsigned SLOW_STAB = SLOW_STAB_CYC
) (
  input  wire logic              clk_sys,               // System clock, 40 MHz
  input  wire logic              reset_n,               // Synchronous reset, active low
  input  wire logic [ADDR_W-1:0] reg_addr,              // Register address
  input  wire logic [DATA_W-1:0] reg_wdata,             // Write data
  input  wire logic              reg_wr,                // Write strobe
  input  wire logic              reg_rd,                // Read strobe
  output logic      [DATA_W-1:0] reg_rdata,             // Read data, cycle after strobe
  input  wire logic              halt_exec,             // CPU executes halt, pulse
  input  wire logic              wake_req,              // Wake-up event, pulse
  input  wire logic              wdt_clear_instr,       // Clear watchdog instruction, pulse
  input  wire logic              wdt_timeout_in,        // Watchdog timed out, pulse
  output logic                   sys_clk_en,            // System clock enable pulse
  output logic                   fast_clk_en,           // Fast oscillator clock enable
  output logic                   slow_clk_en,           // Slow oscillator tick
  output logic                   fast_internal_osc_on,  // Fast oscillator running
  output logic                   slow_internal_osc_on,  // Slow oscillator running
  output logic                   cpu_hold,              // Freeze program, memory, ports
  output logic                   power_down_flag,       // Power-down status
  output logic                   watchdog_timeout_flag, // Timeout status
  output logic                   irq                    // Level interrupt
);

  // Counters are 16 bits wide, so longer settle times cannot be served
  if (FAST_STAB < 1 || SLOW_STAB < 1 || FAST_STAB > 65535 || SLOW_STAB > 65535) begin : g_bad_stab
    $error("Stabilisation counts out of range");
  end

  function automatic logic [6:0] div_mask(input logic [2:0] sel);
    div_mask = 7'((7'h01 << sel) - 7'h01);
  endfunction : div_mask

  logic [2:0]        sys_clk_select_r;
  logic              fast_osc_keep_on_halt_r;
  logic              slow_osc_keep_on_halt_r;
  logic              fast_osc_enable_r;
  logic              fast_osc_stable_flag_r;
  logic [15:0]       fast_stab_cnt_r;
  logic              fast_osc_on_r;
  logic              slow_osc_on_r;
  logic              slow_stable_r;
  logic [15:0]       slow_stab_cnt_r;
  logic [2:0]        slow_div_r;
  logic              slow_tick_r;
  logic [6:0]        div_cnt_r;
  logic [2:0]        active_sel_r;
  logic              active_slow_r;
  op_mode_t          mode_r;
  op_mode_t          mode_nxt;
  logic              halted;
  logic              watchdog_enable_r;
  logic [WDOG_W-1:0] wdog_cnt_r;
  logic [IRQ_N-1:0]  irq_status_r;
  logic [IRQ_N-1:0]  irq_enable_r;
  logic [IRQ_N-1:0]  ev;
  logic              wr_scc;
  logic              wr_fosc;
  logic              stable_rise;

  assign halted = (mode_r != MODE_FAST) && (mode_r != MODE_SLOW);
  assign wr_scc  = reg_wr && (reg_addr == OFS_SYSTEM_CLOCK_CONTROL);
  assign wr_fosc = reg_wr && (reg_addr == OFS_FAST_OSC_CONTROL);

  // Software control bits
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sys_clk_select_r        <= SCC_RESET[SEL_MSB:SEL_LSB];
      fast_osc_keep_on_halt_r <= SCC_RESET[FKEEP_B];
      slow_osc_keep_on_halt_r <= SCC_RESET[SKEEP_B];
      fast_osc_enable_r       <= FEN_RESET;
      watchdog_enable_r       <= 1'b1;
      irq_enable_r            <= '0;
    end else begin
      if (wr_scc) begin
        sys_clk_select_r        <= reg_wdata[SEL_MSB:SEL_LSB];
        fast_osc_keep_on_halt_r <= reg_wdata[FKEEP_B];
        slow_osc_keep_on_halt_r <= reg_wdata[SKEEP_B];
      end
      // RULE6: fast enable control
      if (wr_fosc) begin
        fast_osc_enable_r <= reg_wdata[FEN_B];
      end
      if (reg_wr && reg_addr == OFS_WATCHDOG_CTRL) begin
        watchdog_enable_r <= reg_wdata[0];
      end
      if (reg_wr && reg_addr == OFS_IRQ_ENABLE) begin
        irq_enable_r <= reg_wdata[IRQ_N-1:0];
      end
    end
  end

  // RULE7: halt mode from keep bits
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      MODE_FAST, MODE_SLOW: begin
        if (halt_exec) begin
          case ({fast_osc_keep_on_halt_r, slow_osc_keep_on_halt_r})
            // RULE10: both clear gives sleep
            2'b00:   mode_nxt = MODE_SLEEP;
            // RULE11: slow clock only
            2'b01:   mode_nxt = MODE_HALT_SLOW_ONLY;
            // RULE12: both clocks kept
            2'b11:   mode_nxt = MODE_HALT_BOTH_CLOCKS;
            // RULE13: fast clock only
            default: mode_nxt = MODE_HALT_FAST_ONLY;
          endcase
        end else begin
          mode_nxt = (active_slow_r) ? MODE_SLOW : MODE_FAST;
        end
      end
      MODE_SLEEP, MODE_HALT_SLOW_ONLY, MODE_HALT_BOTH_CLOCKS, MODE_HALT_FAST_ONLY: begin
        if (wake_req || wdt_timeout_in) begin
          mode_nxt = (active_slow_r) ? MODE_SLOW : MODE_FAST;
        end
      end
      default: mode_nxt = MODE_FAST;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      mode_r <= MODE_FAST;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // RULE2: fast oscillator running state
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      fast_osc_on_r <= FEN_RESET;
    end else begin
      case (mode_nxt)
        MODE_SLEEP, MODE_HALT_SLOW_ONLY: fast_osc_on_r <= 1'b0;
        MODE_HALT_BOTH_CLOCKS, MODE_HALT_FAST_ONLY: fast_osc_on_r <= 1'b1;
        default: fast_osc_on_r <= fast_osc_enable_r || !sys_clk_select_r[2] || sys_clk_select_r != SEL_SLOW;
      endcase
    end
  end

  // RULE5: stable flag drops on enable, rises after settling
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      fast_stab_cnt_r        <= '0;
      fast_osc_stable_flag_r <= 1'b0;
    end else if (!fast_osc_on_r || (wr_fosc && reg_wdata[FEN_B] && !fast_osc_enable_r)) begin
      fast_stab_cnt_r        <= '0;
      fast_osc_stable_flag_r <= 1'b0;
    end else if (fast_stab_cnt_r < 16'(FAST_STAB)) begin
      fast_stab_cnt_r <= fast_stab_cnt_r + 16'h0001;
    end else begin
      // RULE4: stability reported
      fast_osc_stable_flag_r <= 1'b1;
    end
  end

  assign stable_rise = fast_osc_on_r && !fast_osc_stable_flag_r && (fast_stab_cnt_r >= 16'(FAST_STAB))
                       && !(wr_fosc && reg_wdata[FEN_B] && !fast_osc_enable_r);

  // RULE3: slow oscillator kept for slow-keep halts or watchdog
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      slow_osc_on_r   <= 1'b1;
      slow_stable_r   <= 1'b0;
      slow_stab_cnt_r <= '0;
    end else begin
      case (mode_nxt)
        MODE_SLEEP: slow_osc_on_r <= watchdog_enable_r;
        MODE_HALT_FAST_ONLY: slow_osc_on_r <= watchdog_enable_r;
        default: slow_osc_on_r <= 1'b1;
      endcase
      if (!slow_osc_on_r) begin
        slow_stable_r   <= 1'b0;
        slow_stab_cnt_r <= '0;
      end else if (slow_stab_cnt_r < 16'(SLOW_STAB)) begin
        slow_stab_cnt_r <= slow_stab_cnt_r + 16'h0001;
      end else begin
        slow_stable_r <= 1'b1;
      end
    end
  end

  // RULE17: slow tick from slow oscillator divider
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      slow_div_r  <= '0;
      slow_tick_r <= 1'b0;
    end else begin
      slow_div_r  <= slow_osc_on_r ? 3'(slow_div_r + 3'h1) : 3'h0;
      slow_tick_r <= slow_osc_on_r && (slow_div_r == 3'(SLOW_TICK_DIV - 1));
    end
  end

  // RULE18: switch source or ratio only at a period boundary
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      active_sel_r  <= SCC_RESET[SEL_MSB:SEL_LSB];
      active_slow_r <= 1'b0;
      div_cnt_r     <= '0;
    end else begin
      if (active_slow_r ? slow_tick_r : (div_cnt_r == 7'h00)) begin
        // RULE8: slow only once slow oscillator stable
        if (sys_clk_select_r == SEL_SLOW && slow_stable_r) begin
          active_slow_r <= 1'b1;
          active_sel_r  <= SEL_SLOW;
        // RULE9: back to fast division
        end else if (sys_clk_select_r <= SEL_MAX_DIV) begin
          active_slow_r <= 1'b0;
          active_sel_r  <= sys_clk_select_r;
        end
      end
      // RULE1: divide fast clock by select code
      if (fast_osc_on_r) begin
        div_cnt_r <= (div_cnt_r == 7'h00) ? div_mask(active_sel_r) : 7'(div_cnt_r - 7'h01);
      end
    end
  end

  // RULE10: system clock stops in any halt mode
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sys_clk_en           <= 1'b0;
      fast_clk_en          <= 1'b0;
      slow_clk_en          <= 1'b0;
      fast_internal_osc_on <= 1'b0;
      slow_internal_osc_on <= 1'b0;
      cpu_hold             <= 1'b0;
    end else begin
      sys_clk_en <= !halted && (active_slow_r ? slow_tick_r : (fast_osc_on_r && div_cnt_r == 7'h00));
      fast_clk_en <= fast_osc_on_r;
      slow_clk_en <= slow_tick_r && (mode_r != MODE_SLEEP);
      fast_internal_osc_on <= fast_osc_on_r;
      slow_internal_osc_on <= slow_osc_on_r;
      // RULE14: hold CPU state while halted
      cpu_hold <= (mode_nxt != MODE_FAST) && (mode_nxt != MODE_SLOW);
    end
  end

  // RULE15: power-down set, timeout cleared on halt
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      power_down_flag       <= 1'b0;
      watchdog_timeout_flag <= 1'b0;
    end else begin
      if (halt_exec && !halted) begin
        power_down_flag <= 1'b1;
      end else if (wdt_clear_instr) begin
        power_down_flag <= 1'b0;
      end
      // A timeout in the halt cycle is not lost
      if (wdt_timeout_in) begin
        watchdog_timeout_flag <= 1'b1;
      end else if (halt_exec && !halted) begin
        watchdog_timeout_flag <= 1'b0;
      end
    end
  end

  // RULE16: watchdog cleared on halt, counts only if enabled
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wdog_cnt_r <= '0;
    end else if ((halt_exec && !halted) || wdt_clear_instr) begin
      wdog_cnt_r <= '0;
    end else if (watchdog_enable_r && slow_tick_r) begin
      wdog_cnt_r <= WDOG_W'(wdog_cnt_r + 1'b1);
    end
  end

  // Sticky events; a new event beats a clear in the same cycle
  assign ev = {(wake_req && halted), stable_rise, (halt_exec && !halted)};

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irq_status_r <= '0;
      irq          <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == OFS_IRQ_CLEAR) begin
        irq_status_r <= (irq_status_r & ~reg_wdata[IRQ_N-1:0]) | ev;
      end else begin
        irq_status_r <= irq_status_r | ev;
      end
      irq <= |(irq_status_r & irq_enable_r);
    end
  end

  // Read port; unmapped addresses read zero
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_SYSTEM_CLOCK_CONTROL:
          reg_rdata <= {sys_clk_select_r, 3'h0, fast_osc_keep_on_halt_r, slow_osc_keep_on_halt_r};
        OFS_FAST_OSC_CONTROL: reg_rdata <= {6'h00, fast_osc_stable_flag_r, fast_osc_enable_r};
        OFS_STATUS:           reg_rdata <= DATA_W'(irq_status_r);
        OFS_IRQ_ENABLE:       reg_rdata <= DATA_W'(irq_enable_r);
        OFS_MODE:             reg_rdata <= {4'h0, active_slow_r, mode_r};
        OFS_WATCHDOG_CTRL:    reg_rdata <= {watchdog_timeout_flag, power_down_flag, 5'h00, watchdog_enable_r};
        OFS_WATCHDOG_COUNT:   reg_rdata <= wdog_cnt_r[DATA_W-1:0];
        default:              reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule : system_clock_mode_control

// >>> clk_mode_pkg.sv
// Package of register map, field layout, modes and timing for the clock and mode control
package clk_mode_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // Register byte offsets
  localparam logic [3:0] OFS_SYSTEM_CLOCK_CONTROL = 4'h0;
  localparam logic [3:0] OFS_FAST_OSC_CONTROL     = 4'h1;
  localparam logic [3:0] OFS_STATUS               = 4'h2;
  localparam logic [3:0] OFS_IRQ_ENABLE           = 4'h3;
  localparam logic [3:0] OFS_IRQ_CLEAR            = 4'h4;
  localparam logic [3:0] OFS_MODE                 = 4'h5;
  localparam logic [3:0] OFS_WATCHDOG_CTRL        = 4'h6;
  localparam logic [3:0] OFS_WATCHDOG_COUNT       = 4'h7;

  // System clock control fields
  localparam int unsigned SEL_LSB  = 5;
  localparam int unsigned SEL_MSB  = 7;
  localparam int unsigned FKEEP_B  = 1;
  localparam int unsigned SKEEP_B  = 0;
  // Fast oscillator control fields
  localparam int unsigned FSTAB_B  = 1;
  localparam int unsigned FEN_B    = 0;

  localparam logic [2:0] SEL_SLOW      = 3'h7;
  localparam logic [2:0] SEL_MAX_DIV   = 3'h6;
  localparam logic [7:0] SCC_RESET     = 8'h00;
  localparam logic       FEN_RESET     = 1'b1;

  // Status and interrupt bit positions
  localparam int unsigned IRQ_N        = 3;
  localparam int unsigned EV_HALT      = 0;
  localparam int unsigned EV_STABLE    = 1;
  localparam int unsigned EV_WAKE      = 2;

  // Oscillator stabilisation time in ns, and cycles at 40 MHz
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned FAST_STAB_NS   = 1000;
  localparam int unsigned FAST_STAB_CYC  = (FAST_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SLOW_STAB_NS   = 2000;
  localparam int unsigned SLOW_STAB_CYC  = (SLOW_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SLOW_TICK_DIV  = 8;
  localparam int unsigned WDOG_W         = 16;

  // Operating modes, Gray coded in listing order
  typedef enum logic [2:0] {
    MODE_FAST             = 3'b000,
    MODE_SLOW             = 3'b001,
    MODE_SLEEP            = 3'b011,
    MODE_HALT_SLOW_ONLY   = 3'b010,
    MODE_HALT_BOTH_CLOCKS = 3'b110,
    MODE_HALT_FAST_ONLY   = 3'b111
  } op_mode_t;
endpackage : clk_mode_pkg

// >>> clk_mode_sva.sv
// Port-level assertions for the clock and mode control
`timescale 1ns/1ps
module clk_mode_sva
  import clk_mode_pkg::*;
(
  input wire logic              clk_sys,               // Clock
  input wire logic              reset_n,               // Sync reset
  input wire logic [ADDR_W-1:0] reg_addr,              // Address
  input wire logic [DATA_W-1:0] reg_wdata,             // Write data
  input wire logic              reg_wr,                // Write strobe
  input wire logic              reg_rd,                // Read strobe
  input wire logic [DATA_W-1:0] reg_rdata,             // Read data
  input wire logic              halt_exec,             // Halt pulse
  input wire logic              wake_req,              // Wake pulse
  input wire logic              wdt_timeout_in,        // Timeout pulse
  input wire logic              sys_clk_en,            // System clock pulse
  input wire logic              slow_clk_en,           // Slow tick
  input wire logic              fast_clk_en,           // Fast clock enable
  input wire logic              fast_internal_osc_on,  // Fast osc running
  input wire logic              slow_internal_osc_on,  // Slow osc running
  input wire logic              cpu_hold,              // Halted
  input wire logic              power_down_flag,       // Power-down flag
  input wire logic              watchdog_timeout_flag  // Timeout flag
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic [7:0] scc_r;
  logic       wden_r;
  logic [7:0] quiet_r;
  logic [7:0] gap_r;
  logic [2:0] hold_cnt_r;
  logic [7:0] per;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) scc_r <= SCC_RESET;
    else if (reg_wr && reg_addr == OFS_SYSTEM_CLOCK_CONTROL) scc_r <= reg_wdata;
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n) wden_r <= 1'b1;
    else if (reg_wr && reg_addr == OFS_WATCHDOG_CTRL) wden_r <= reg_wdata[0];
  end
  // Period check only after switches have long settled
  always_ff @(posedge clk_sys) begin
    if (!reset_n || cpu_hold || (reg_wr && reg_addr <= OFS_FAST_OSC_CONTROL)) quiet_r <= 8'h00;
    else if (quiet_r != 8'hff) quiet_r <= quiet_r + 8'h01;
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n || sys_clk_en) gap_r <= 8'h01;
    else if (gap_r != 8'hff) gap_r <= gap_r + 8'h01;
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !cpu_hold) hold_cnt_r <= 3'h0;
    else if (hold_cnt_r != 3'h7) hold_cnt_r <= hold_cnt_r + 3'h1;
  end
  assign per = (scc_r[SEL_MSB:SEL_LSB] == SEL_SLOW) ? 8'(SLOW_TICK_DIV) : 8'(1 << scc_r[SEL_MSB:SEL_LSB]);

  AST_RDATA_IDLE: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside answer cycle");
  AST_SYSCLK_PERIOD: assert property (
    sys_clk_en && quiet_r == 8'hff |-> gap_r == per) else $error("system clock period wrong");
  AST_HALT_ENTRY: assert property (
    halt_exec && !cpu_hold |=> cpu_hold && power_down_flag && !watchdog_timeout_flag)
    else $error("halt entry flags wrong");
  AST_HOLD_KEEPS: assert property (
    cpu_hold && !wake_req && !wdt_timeout_in |=> cpu_hold) else $error("hold dropped without wake");
  AST_HALT_NO_SYSCLK: assert property (
    hold_cnt_r >= 3'h2 |-> !sys_clk_en) else $error("system clock runs in halt");
  AST_FAST_KEEP: assert property (
    hold_cnt_r == 3'h7 |-> fast_internal_osc_on == scc_r[FKEEP_B]) else $error("fast osc state in halt");
  AST_SLOW_KEEP: assert property (
    hold_cnt_r == 3'h7 |-> slow_internal_osc_on == (scc_r[SKEEP_B] | wden_r)) else $error("slow osc state in halt");
  AST_SLEEP_NO_TICK: assert property (
    hold_cnt_r == 3'h7 && scc_r[1:0] == 2'b00 |-> !slow_clk_en) else $error("slow tick in sleep");
  AST_SLOW_TICK_HALT: assert property (
    hold_cnt_r == 3'h7 && scc_r[SKEEP_B] |-> ##[0:16] slow_clk_en) else $error("slow tick missing in halt");
  AST_FAST_CLK_SRC: assert property (
    fast_clk_en == fast_internal_osc_on) else $error("fast clock enable without fast oscillator");
endmodule : clk_mode_sva
bind system_clock_mode_control clk_mode_sva u_sva (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_exec(halt_exec),
  .wake_req(wake_req), .wdt_timeout_in(wdt_timeout_in), .sys_clk_en(sys_clk_en), .slow_clk_en(slow_clk_en),
  .fast_clk_en(fast_clk_en), .fast_internal_osc_on(fast_internal_osc_on), .slow_internal_osc_on(slow_internal_osc_on),
  .cpu_hold(cpu_hold), .power_down_flag(power_down_flag), .watchdog_timeout_flag(watchdog_timeout_flag));

// >>> testbench.sv
// Self-checking testbench for the clock and mode control
`timescale 1ns/1ps
module testbench;
  import clk_mode_pkg::*;
  logic              clk_sys = 1'b0;
  logic              reset_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic [DATA_W-1:0] reg_rdata, last_rd;
  logic              reg_wr = 1'b0, reg_rd = 1'b0, halt_exec = 1'b0, wake_req = 1'b0;
  logic              wdt_clr = 1'b0, wdt_tmo = 1'b0;
  logic              sys_clk_en, fast_clk_en, slow_clk_en, fast_on, slow_on, cpu_hold, pwr_dn, wdt_flag, irq;
  logic [15:0]       exp_q[$];
  op_mode_t          modes[4] = '{MODE_SLEEP, MODE_HALT_SLOW_ONLY, MODE_HALT_FAST_ONLY, MODE_HALT_BOTH_CLOCKS};
  int                n_mismatch = 0, n_compared = 0;

  system_clock_mode_control #(.FAST_STAB(2), .SLOW_STAB(2)) dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .halt_exec(halt_exec), .wake_req(wake_req), .wdt_clear_instr(wdt_clr), .wdt_timeout_in(wdt_tmo),
    .sys_clk_en(sys_clk_en), .fast_clk_en(fast_clk_en), .slow_clk_en(slow_clk_en), .fast_internal_osc_on(fast_on),
    .slow_internal_osc_on(slow_on), .cpu_hold(cpu_hold), .power_down_flag(pwr_dn),
    .watchdog_timeout_flag(wdt_flag), .irq(irq));

  always #12.5 clk_sys = ~clk_sys;

  task summarize;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task cyc(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  task wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b0;
    @(posedge clk_sys);
  endtask : wr

  // Expectation noted with a mask of the bits that matter
  task rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    exp_q.push_back({m, e});
    reg_addr <= a;
    reg_rd   <= 1'b1;
    reg_wr   <= 1'b0;
    @(posedge clk_sys);
  endtask : rd

  task poll_stable;
    int i;
    for (i = 0; i < 30; i++) begin
      rd(OFS_FAST_OSC_CONTROL, 8'h00, 8'h00);
      cyc(2);
      if (last_rd[FSTAB_B] === 1'b1) break;
    end
    if (i == 30) begin
      n_mismatch++;
      summarize();
    end
  endtask : poll_stable

  task do_halt;
    halt_exec <= 1'b1;
    @(posedge clk_sys);
    halt_exec <= 1'b0;
    #1;
  endtask : do_halt

  task do_wake;
    wake_req <= 1'b1;
    @(posedge clk_sys);
    wake_req <= 1'b0;
    #1;
  endtask : do_wake

  always @(posedge clk_sys) begin : watch
    logic        hit;
    logic [15:0] e;
    hit = reg_rd;
    #1;
    if (hit) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("FAIL t=%0t seen=%h exp=%h", $time, reg_rdata, 8'h00);
      end else begin
        e = exp_q.pop_front();
        last_rd = reg_rdata;
        check(reg_rdata & e[15:8], e[7:0]);
      end
    end
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    n_mismatch++;
    summarize();
  end

  initial begin
    int i;
    logic [1:0] kp;
    logic [2:0] s;
    i = $urandom(61);
    cyc(3);
    reset_n <= 1'b1;
    cyc(1);
    rd(OFS_SYSTEM_CLOCK_CONTROL, 8'hff, SCC_RESET);
    rd(OFS_FAST_OSC_CONTROL, 8'hfd, 8'h01);
    rd(4'hf, 8'hff, 8'h00);
    wr(4'hf, 8'($urandom));
    cyc(1);
    poll_stable();
    // Walk every select code, reserved bits random
    for (i = 0; i < 8; i++) begin
      s = 3'(i);
      wr(OFS_SYSTEM_CLOCK_CONTROL, {s, 3'($urandom), 2'b00});
      rd(OFS_SYSTEM_CLOCK_CONTROL, 8'hff, {s, 5'h00});
      cyc(300);
      rd(OFS_MODE, 8'h0f, {4'h0, s == SEL_SLOW, (s == SEL_SLOW) ? MODE_SLOW : MODE_FAST});
    end
    // Running slow: fast osc may be switched off and back on
    wr(OFS_FAST_OSC_CONTROL, 8'h00);
    cyc(10);
    #1;
    check({7'h0, fast_on}, 8'h00);
    @(posedge clk_sys);
    wr(OFS_FAST_OSC_CONTROL, 8'h01);
    rd(OFS_FAST_OSC_CONTROL, 8'h03, 8'h01);
    cyc(1);
    poll_stable();
    // Slow back to fast at divide by 4
    wr(OFS_SYSTEM_CLOCK_CONTROL, 8'h40);
    cyc(300);
    rd(OFS_MODE, 8'h0f, {4'h0, 1'b0, MODE_FAST});
    cyc(1);
    wr(OFS_WATCHDOG_CTRL, 8'h00);
    for (i = 0; i < 4; i++) begin
      kp = 2'(i);
      wr(OFS_SYSTEM_CLOCK_CONTROL, {3'($urandom_range(7, 0)), 3'b000, kp});
      wr(OFS_IRQ_ENABLE, {7'h0, kp != 2'b00});
      cyc(2);
      do_halt();
      check({5'h0, cpu_hold, pwr_dn, wdt_flag}, 8'h06);
      @(posedge clk_sys);
      cyc(7);
      #1;
      check({4'h0, fast_on, slow_on, irq, sys_clk_en}, {4'h0, kp, kp != 2'b00, 1'b0});
      @(posedge clk_sys);
      rd(OFS_MODE, 8'h07, {5'h0, modes[kp]});
      rd(OFS_STATUS, 8'h01, 8'h01);
      rd(OFS_WATCHDOG_COUNT, 8'hff, 8'h00);
      cyc(1);
      do_wake();
      check({7'h0, cpu_hold}, 8'h00);
      @(posedge clk_sys);
      wr(OFS_IRQ_CLEAR, 8'h07);
      cyc(3);
      #1;
      check({7'h0, irq}, 8'h00);
      @(posedge clk_sys);
    end
    // Timeout wakes and flags; next halt clears it
    wr(OFS_WATCHDOG_CTRL, 8'h01);
    cyc(1);
    do_halt();
    @(posedge clk_sys);
    wdt_tmo <= 1'b1;
    @(posedge clk_sys);
    wdt_tmo <= 1'b0;
    #1;
    check({6'h0, cpu_hold, wdt_flag}, 8'h01);
    @(posedge clk_sys);
    do_halt();
    check({6'h0, pwr_dn, wdt_flag}, 8'h02);
    @(posedge clk_sys);
    do_wake();
    @(posedge clk_sys);
    wdt_clr <= 1'b1;
    @(posedge clk_sys);
    wdt_clr <= 1'b0;
    cyc(2);
    rd(OFS_WATCHDOG_CTRL, 8'hc1, 8'h01);
    cyc(3);
    summarize();
  end
endmodule : testbench
